// file: rtl/port_pin_change_detector.sv
// pin change detector: per-pin edge enables, sticky flags, wake request
// Function
// - writing zero to a flag bit clears that pin change flag.
// - an enabled edge in the same cycle as a clearing write keeps the flag set.
// - with the master enable set, an enabled edge raises a wake-up request.
// - edges are recorded by logic that runs on the system clock, not the cpu.
// - the rising enable register has one bit per pin, reset to zero.
// - the falling enable register has one bit per pin, reset to zero.
// - a flag sets on an enabled rising edge or an enabled falling edge.
// - the flag register is hardware set, software read/write, reset to zero.
// - edges are flagged even while the master enable is clear.
// - the summary bit is the OR of all flags and requests when enabled.
// - a pin with both enables set flags edges of either polarity.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module port_pin_change_detector
    import pin_change_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clock_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PIN_COUNT-1:0] port_b_pin,
    output logic change_int_request,
    output logic wake_request
);
    typedef struct packed {
        logic [PIN_COUNT-1:0] rise_edge_enable;
        logic [PIN_COUNT-1:0] fall_edge_enable;
        logic [PIN_COUNT-1:0] pin_change_flags;
        logic change_int_master_enable;
        logic [PIN_COUNT-1:0] last_pins;
        logic primed;
        logic [1:0] settle;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
        logic wake;
    } det_state_t;

    det_state_t state;
    det_state_t next_state;
    logic [PIN_COUNT-1:0] synced_pins;
    logic [PIN_COUNT-1:0] edge_hits;
    logic setup_phase;
    // enabled edges after reset before both compare inputs hold pin levels
    localparam logic [1:0] SETTLE_DONE = 2'(SYNC_STAGES + 1);

    // pins come from outside the clock domain
    pin_sync_regs u_sync (
        .clock(clock),
        .nrst(nrst),
        .clock_en(clock_en),
        .raw_pins(port_b_pin),
        .synced_pins(synced_pins)
    );

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFFS_RISE) || (a == OFFS_FALL) ||
                    (a == OFFS_FLAGS) || (a == OFFS_CTRL);
    endfunction

    // rising and falling transitions gated by their enables
    assign edge_hits = state.primed ?
        ((synced_pins & ~state.last_pins & state.rise_edge_enable) |
         (~synced_pins & state.last_pins & state.fall_edge_enable))
        : '0;

    // answer in the setup cycle, so pready rises one cycle later
    assign setup_phase = psel && !penable;

    always_comb begin
        logic [PIN_COUNT-1:0] flags_after;
        logic any_flag;
        flags_after = state.pin_change_flags;
        any_flag = 1'b0;
        next_state = state;
        if (clock_en) begin
            next_state.last_pins = synced_pins;
            // the synchroniser and last sample restart at zero, so a pin
            // held high through reset would look like a rising edge
            if (state.settle != SETTLE_DONE) begin
                next_state.settle = state.settle + 2'h1;
            end
            next_state.primed = (next_state.settle == SETTLE_DONE);
            next_state.ready = 1'b0;
            next_state.slverr = 1'b0;
            if (setup_phase) begin
                next_state.ready = 1'b1;
                next_state.slverr = !is_mapped(paddr);
                next_state.rdata = READ_ZERO;
                if (pwrite) begin
                    if (paddr == OFFS_RISE) begin
                        next_state.rise_edge_enable =
                            pwdata[PIN_COUNT-1:0];
                    end else if (paddr == OFFS_FALL) begin
                        next_state.fall_edge_enable =
                            pwdata[PIN_COUNT-1:0];
                    end else if (paddr == OFFS_FLAGS) begin
                        // writes can only clear; ones written leave bits alone
                        flags_after = state.pin_change_flags &
                            pwdata[PIN_COUNT-1:0];
                    end else if (paddr == OFFS_CTRL) begin
                        next_state.change_int_master_enable =
                            pwdata[CTRL_MASTER_BIT];
                    end
                end else begin
                    if (paddr == OFFS_RISE) begin
                        next_state.rdata[PIN_COUNT-1:0] =
                            state.rise_edge_enable;
                    end else if (paddr == OFFS_FALL) begin
                        next_state.rdata[PIN_COUNT-1:0] =
                            state.fall_edge_enable;
                    end else if (paddr == OFFS_FLAGS) begin
                        next_state.rdata[PIN_COUNT-1:0] =
                            state.pin_change_flags;
                    end else if (paddr == OFFS_CTRL) begin
                        next_state.rdata[CTRL_MASTER_BIT] =
                            state.change_int_master_enable;
                        next_state.rdata[CTRL_SUMMARY_BIT] =
                            |state.pin_change_flags;
                    end
                end
            end
            // set wins over the clearing write; flags record regardless
            // of master enable
            next_state.pin_change_flags = flags_after | edge_hits;
            any_flag = |next_state.pin_change_flags;
            next_state.irq = any_flag && next_state.change_int_master_enable;
            // no cpu clock needed: this logic is the wake source
            next_state.wake = any_flag &&
                next_state.change_int_master_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.rdata;
    assign pready = state.ready;
    assign pslverr = state.slverr;
    assign change_int_request = state.irq;
    assign wake_request = state.wake;

    sequence clear_write_s;
        psel && !penable && pwrite && paddr == OFFS_FLAGS && clock_en;
    endsequence

    property clear_drops_p;
        @(posedge clock) disable iff (!nrst)
        clear_write_s ##0 edge_hits == '0 ##0 pwdata[PIN_COUNT-1:0] == '0
        |=> state.pin_change_flags == '0;
    endproperty
    flag_clear_a: assert property (clear_drops_p)
        else $error("flag clear write did not drop flags");

    property set_wins_p;
        @(posedge clock) disable iff (!nrst)
        clear_write_s ##0 edge_hits != '0
        |=> (state.pin_change_flags & $past(edge_hits)) == $past(edge_hits);
    endproperty
    set_wins_a: assert property (set_wins_p)
        else $error("edge lost during flag clear");

    edge_sets_a: assert property (@(posedge clock) disable iff (!nrst)
        clock_en && edge_hits != '0 |=> wake_request ||
        !state.change_int_master_enable)
        else $error("enabled edge gave no wake request");

    rise_reset_a: assert property (@(posedge clock)
        !nrst |=> state.rise_edge_enable == RESET_BYTE)
        else $error("rise enables not reset");

    fall_reset_a: assert property (@(posedge clock)
        !nrst |=> state.fall_edge_enable == RESET_BYTE)
        else $error("fall enables not reset");

    rise_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        clock_en && state.primed && synced_pins[0] && !state.last_pins[0]
        && state.rise_edge_enable[0] |=> state.pin_change_flags[0])
        else $error("rising edge not flagged");

    no_spurious_a: assert property (@(posedge clock) disable iff (!nrst)
        clock_en && !(setup_phase && pwrite) && edge_hits == '0
        |=> state.pin_change_flags == $past(state.pin_change_flags))
        else $error("flags changed without cause");

    masked_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        clock_en && edge_hits != '0 && !state.change_int_master_enable
        && !setup_phase |=> state.pin_change_flags != '0 ##0
        !change_int_request)
        else $error("masked edge not recorded or irq leaked");

    summary_a: assert property (@(posedge clock) disable iff (!nrst)
        change_int_request == ($past(|next_state.pin_change_flags) &&
        $past(next_state.change_int_master_enable)) || !$past(clock_en) ||
        !$past(nrst))
        else $error("summary request wrong");

    fall_flag_a: assert property (@(posedge clock) disable iff (!nrst)
        clock_en && state.primed && !synced_pins[0] && state.last_pins[0]
        && state.fall_edge_enable[0] |=> state.pin_change_flags[0])
        else $error("falling edge not flagged");

    flags_reset_a: assert property (@(posedge clock)
        !nrst |=> state.pin_change_flags == RESET_BYTE)
        else $error("flags not reset");

    prime_hold_a: assert property (@(posedge clock)
        !nrst |=> !state.primed ##1 !state.primed)
        else $error("edge compare armed before synchroniser filled");

    wake_match_a: assert property (@(posedge clock) disable iff (!nrst)
        wake_request == change_int_request)
        else $error("wake request differs from interrupt request");
endmodule
`default_nettype wire

// file: rtl/pin_change_pkg.sv
// shared register map, field positions and reset values of the pin change unit
package pin_change_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFFS_RISE = 12'h000;
    localparam logic [11:0] OFFS_FALL = 12'h004;
    localparam logic [11:0] OFFS_FLAGS = 12'h008;
    localparam logic [11:0] OFFS_CTRL = 12'h00C;
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h00000000;
    localparam int SYNC_STAGES = 2;
endpackage

// file: rtl/pin_sync_regs.sv
// two-stage synchroniser register bank for the port pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync_regs
    import pin_change_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clock_en,
    input wire logic [PIN_COUNT-1:0] raw_pins,
    output logic [PIN_COUNT-1:0] synced_pins
);
    typedef struct packed {
        logic [PIN_COUNT-1:0] first;
        logic [PIN_COUNT-1:0] second;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state = state;
        if (clock_en) begin
            next_state.first = raw_pins;
            next_state.second = state.first;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign synced_pins = state.second;
endmodule
`default_nettype wire

// file: dv/pin_source.sv
// external pin source: drives the port pins a little after each change
`timescale 1ns/1ns
`default_nettype none
module pin_source (
    input wire logic [7:0] level,
    output logic [7:0] pins
);
    // lands off the clock edge, as a truly asynchronous input would
    // runs once at time zero too, so the pins turn known 3 ns in, not at the first change
    always begin
        pins <= #3 level;
        @(level);
    end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the pin change detector
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pin_change_pkg::*;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } row_t;
    logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic clock_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, r;
    logic pready, pslverr, req, wake, e;
    logic [7:0] level = 8'h00;
    logic [7:0] pins;
    int errors = 0, total_checks = 0;
    row_t rows [5] = '{'{OFFS_RISE, 32'hFFFFFFA5, 32'h000000A5, 1'b0},
        '{OFFS_FALL, 32'h0000013C, 32'h0000003C, 1'b0},
        '{OFFS_FLAGS, 32'h000000FF, 32'h00000000, 1'b0},
        '{OFFS_CTRL, 32'h00000001, 32'h00000001, 1'b0},
        '{12'h010, 32'h12345678, 32'h00000000, 1'b1}};
    port_pin_change_detector u_port_pin_change_detector (.clock(clock),
        .nrst(nrst), .clock_en(clock_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_b_pin(pins),
        .change_int_request(req), .wake_request(wake));
    pin_source u_pin_source (.level(level), .pins(pins));
    initial forever #10 clock = ~clock;
    task stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // the slave answers when it likes; the wait ends on pready or at the 20-cycle bound
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errors++;
            $display("[ERR] %0t no answer on the bus", $time);
            stop_test;
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        chk(r, x);
    endtask
    task edge_to(input logic [7:0] v);
        @(posedge clock);
        level <= v;
        repeat (6) @(posedge clock);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rd(OFFS_RISE, 32'h00000000);
        rd(OFFS_FALL, 32'h00000000);
        rd(OFFS_FLAGS, 32'h00000000);
        rd(OFFS_CTRL, 32'h00000000);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk({31'h0, e}, {31'h0, rows[i].e});
            rd(rows[i].a, rows[i].x);
        end
        apb(1'b1, OFFS_RISE, 32'h00000055);
        apb(1'b1, OFFS_FALL, 32'h0000000F);
        apb(1'b1, OFFS_CTRL, 32'h00000000);
        edge_to(8'hFF);
        rd(OFFS_FLAGS, 32'h00000055);
        chk({31'h0, req}, 32'h0);
        chk({31'h0, wake}, 32'h0);
        rd(OFFS_CTRL, 32'h00000002);
        // software clears only what it saw set
        apb(1'b0, OFFS_FLAGS, 32'h00000000);
        apb(1'b1, OFFS_FLAGS, r ^ 32'h000000FF);
        rd(OFFS_FLAGS, 32'h00000000);
        edge_to(8'h00);
        rd(OFFS_FLAGS, 32'h0000000F);
        apb(1'b1, OFFS_CTRL, 32'h00000001);
        chk({31'h0, req}, 32'h1);
        chk({31'h0, wake}, 32'h1);
        apb(1'b1, OFFS_FLAGS, 32'h000000FE);
        rd(OFFS_FLAGS, 32'h0000000E);
        apb(1'b1, OFFS_FLAGS, 32'h00000000);
        chk({31'h0, req}, 32'h0);
        // clearing write lands before, on and after the flag-set edge
        apb(1'b1, OFFS_RISE, 32'h00000080);
        apb(1'b1, OFFS_FALL, 32'h00000000);
        for (int d = 0; d < 3; d++) begin
            @(posedge clock);
            level <= 8'h80;
            repeat (d) @(posedge clock);
            apb(1'b1, OFFS_FLAGS, 32'h00000000);
            repeat (6) @(posedge clock);
            rd(OFFS_FLAGS, (d <= 1) ? 32'h00000080 : 32'h00000000);
            edge_to(8'h00);
            apb(1'b1, OFFS_FLAGS, 32'h00000000);
        end
        // frozen clock enable: a pin edge waits until the enable returns
        @(posedge clock);
        clock_en <= 1'b0;
        level <= 8'h80;
        repeat (6) @(posedge clock);
        chk({31'h0, req}, 32'h0);
        clock_en <= 1'b1;
        repeat (6) @(posedge clock);
        chk({31'h0, req}, 32'h1);
        // reset with the pin held high: no false rising edge afterwards
        @(posedge clock);
        nrst <= 1'b0;
        @(posedge clock);
        nrst <= 1'b1;
        apb(1'b1, OFFS_RISE, 32'h00000080);
        rd(OFFS_FLAGS, 32'h00000000);
        chk({31'h0, wake}, 32'h0);
        rd(OFFS_RISE, 32'h00000080);
        rd(OFFS_CTRL, 32'h00000000);
        stop_test;
    end
endmodule
`default_nettype wire
